// File: wut_pkg.sv
package wut_pkg;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_CONTROL     = 6'h23;
    localparam logic [5:0] IDX_RELOAD_HIGH = 6'h24;
    localparam logic [5:0] IDX_RELOAD_LOW  = 6'h25;
    localparam logic [5:0] IDX_COUNT_HIGH  = 6'h26;
    localparam logic [5:0] IDX_COUNT_LOW   = 6'h27;
    localparam logic [5:0] IDX_AUX_CONTROL = 6'h30;
    localparam logic [5:0] IDX_STATUS      = 6'h31;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_RUNNING_BIT   = 7;
    localparam int CTRL_STROBE_BIT    = 6;
    localparam int CTRL_TRIM_BIT      = 5;
    localparam int CTRL_CARD_BIT      = 4;
    localparam int CTRL_RELOAD_BIT    = 3;
    localparam int CTRL_WAKE_BIT      = 2;
    localparam int CTRL_CLKSEL_LSB    = 0;
    localparam int AUX_PD_EN_BIT      = 0;
    localparam int AUX_STAY_EN_BIT    = 1;
    localparam int STATUS_FLAG_BIT    = 0;

    // ---------------------------------------------------------------
    // Values after reset
    // ---------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] RELOAD_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [1:0]  AUX_RESET     = 2'h0;

    // ---------------------------------------------------------------
    // Clock select codes and prescaler terminal counts
    // ---------------------------------------------------------------
    localparam logic [1:0] CLKSEL_DIV1  = 2'h0;
    localparam logic [1:0] CLKSEL_DIV8  = 2'h1;
    localparam logic [1:0] CLKSEL_DIV16 = 2'h2;
    localparam logic [1:0] CLKSEL_DIV32 = 2'h3;
    localparam logic [4:0] DIV8_LAST    = 5'h07;
    localparam logic [4:0] DIV16_LAST   = 5'h0F;
    localparam logic [4:0] DIV32_LAST   = 5'h1F;

    typedef enum logic [2:0] {
        WUT_CD_IDLE = 3'h1,
        WUT_CD_RF   = 3'h2,
        WUT_CD_MEAS = 3'h4
    } wut_cd_state_t;

    typedef struct packed {
        logic [2:0]    lfo_sync;
        logic          lfo_lvl;
        logic [4:0]    pre;
        logic          running;
        logic [15:0]   cnt;
        logic [15:0]   reload;
        logic          auto_trim;
        logic          auto_card;
        logic          auto_reload;
        logic          auto_wake;
        logic [1:0]    clksel;
        logic          pd_en;
        logic          stay_en;
        logic          flag;
        wut_cd_state_t cd;
        logic          ack;
        logic [7:0]    rdata;
        logic          wake;
        logic          trim_start;
        logic          rf_start;
        logic          card_start;
        logic          card_irq;
        logic          stay;
        logic          pd_req;
    } wut_state_t;

endpackage

// File: wut_wakeup_timer.sv
`timescale 1ns/1ns
// Contract
// - Control bit 7 reads whether the counter is running, updated by hardware.
// - Control write changes running only when the same write sets bit 6.
// - Auto-trim bit 5 launches oscillator trimming on each underflow.
// - Auto card-detect bit 4 starts card detection on underflow; found card raises request.
// - No card found enters power-down when power-down entry is enabled.
// - Counter restarts after card-detect underflow with no idle gap.
// - Rf window timer defines how long the field is on during detection.
// - Auto-reload bit 3 reloads counter from reload value at underflow.
// - Without auto-reload or auto card-detect the counter reaches zero then stops, clearing running.
// - Every underflow sets the wake-up underflow flag.
// - Auto-wake bit 2 wakes the chip on underflow.
// - Clock select 00 undivided, 01 by 8, 10 by 16, 11 by 32.
// - Start loads counter from reload; reload writes wait for next start, or next underflow with auto-reload or auto card-detect.
// - Reload value held as high byte 24h and low byte 25h, read/write.
// - Live counter readable as high byte 26h and low byte 27h.
// - Control at 23h: running, strobe, trim, card, reload, wake, clock select.
module wut_wakeup_timer #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              low_freq_osc_clock_i,
    input  wire logic              rf_window_done_i,
    input  wire logic              card_detect_done_i,
    input  wire logic              card_found_i,
    output logic                   wakeup_running_o,
    output logic                   wakeup_underflow_flag_o,
    output logic                   wake_req_o,
    output logic                   osc_trim_start_o,
    output logic                   rf_window_start_o,
    output logic                   rf_field_en_o,
    output logic                   card_detect_start_o,
    output logic                   card_irq_o,
    output logic                   stay_active_o,
    output logic                   power_down_req_o
);

    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8 to reach every register");
    end

    wut_pkg::wut_state_t st_q;
    wut_pkg::wut_state_t st_d;

    logic [5:0] idx;
    logic       bus_req;
    logic       bus_wr;
    logic       ctrl_wr;
    logic       start_wr;
    logic       lfo_rise;
    logic [4:0] pre_last;
    logic       tick;
    logic       underflow;
    logic [7:0] rd_mux;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    assign idx      = wb_adr_i[7:2];
    assign bus_req  = wb_cyc_i & wb_stb_i;
    // A write takes effect at the edge where the master sees ack
    assign bus_wr   = bus_req & wb_we_i & wb_sel_i[0] & st_q.ack;
    assign ctrl_wr  = bus_wr & (idx == wut_pkg::IDX_CONTROL);
    assign start_wr = ctrl_wr & wb_dat_i[wut_pkg::CTRL_STROBE_BIT];

    // ---------------------------------------------------------------
    // Count clock
    // ---------------------------------------------------------------
    // Rising edge once the second and third sync stages agree high
    assign lfo_rise = st_q.lfo_sync[1] & st_q.lfo_sync[2] & ~st_q.lfo_lvl;

    always_comb begin
        case (st_q.clksel)
            wut_pkg::CLKSEL_DIV8:  pre_last = wut_pkg::DIV8_LAST;
            wut_pkg::CLKSEL_DIV16: pre_last = wut_pkg::DIV16_LAST;
            wut_pkg::CLKSEL_DIV32: pre_last = wut_pkg::DIV32_LAST;
            default:               pre_last = 5'h00;
        endcase
    end

    assign tick      = lfo_rise & (st_q.pre == pre_last);
    assign underflow = tick & st_q.running & (st_q.cnt == 16'h0000) & ~ctrl_wr;

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        case (idx)
            wut_pkg::IDX_CONTROL: begin
                rd_mux[wut_pkg::CTRL_RUNNING_BIT] = st_q.running;
                rd_mux[wut_pkg::CTRL_STROBE_BIT]  = 1'b0;
                rd_mux[wut_pkg::CTRL_TRIM_BIT]    = st_q.auto_trim;
                rd_mux[wut_pkg::CTRL_CARD_BIT]    = st_q.auto_card;
                rd_mux[wut_pkg::CTRL_RELOAD_BIT]  = st_q.auto_reload;
                rd_mux[wut_pkg::CTRL_WAKE_BIT]    = st_q.auto_wake;
                rd_mux[wut_pkg::CTRL_CLKSEL_LSB+:2] = st_q.clksel;
            end
            wut_pkg::IDX_RELOAD_HIGH: rd_mux = st_q.reload[15:8];
            wut_pkg::IDX_RELOAD_LOW:  rd_mux = st_q.reload[7:0];
            wut_pkg::IDX_COUNT_HIGH:  rd_mux = st_q.cnt[15:8];
            wut_pkg::IDX_COUNT_LOW:   rd_mux = st_q.cnt[7:0];
            wut_pkg::IDX_AUX_CONTROL: begin
                rd_mux[wut_pkg::AUX_PD_EN_BIT]   = st_q.pd_en;
                rd_mux[wut_pkg::AUX_STAY_EN_BIT] = st_q.stay_en;
            end
            wut_pkg::IDX_STATUS: rd_mux[wut_pkg::STATUS_FLAG_BIT] = st_q.flag;
            default: rd_mux = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.wake       = 1'b0;
        st_d.trim_start = 1'b0;
        st_d.rf_start   = 1'b0;
        st_d.card_start = 1'b0;
        st_d.card_irq   = 1'b0;
        st_d.stay       = 1'b0;
        st_d.pd_req     = 1'b0;

        // Pin synchroniser and filtered level
        st_d.lfo_sync = {st_q.lfo_sync[1:0], low_freq_osc_clock_i};
        if (st_q.lfo_sync[1] == st_q.lfo_sync[2]) begin
            st_d.lfo_lvl = st_q.lfo_sync[2];
        end

        // Bus slave: one ack per request, dropped the cycle after
        st_d.ack = bus_req & ~st_q.ack;
        if (bus_req & ~st_q.ack) begin
            st_d.rdata = rd_mux;
        end

        // Prescaler
        if (lfo_rise) begin
            st_d.pre = (st_q.pre >= pre_last) ? 5'h00 : st_q.pre + 5'h01;
        end

        // Counter
        if (tick & st_q.running & ~ctrl_wr) begin
            if (st_q.cnt != 16'h0000) begin
                st_d.cnt = st_q.cnt - 16'h0001;
            end else if (st_q.auto_reload | st_q.auto_card) begin
                st_d.cnt = st_q.reload;
            end else begin
                st_d.running = 1'b0;
            end
        end

        // Underflow side effects
        if (underflow) begin
            st_d.flag       = 1'b1;
            st_d.wake       = st_q.auto_wake;
            st_d.trim_start = st_q.auto_trim;
        end

        // Card detection sequence
        case (st_q.cd)
            wut_pkg::WUT_CD_IDLE: begin
                if (underflow & st_q.auto_card) begin
                    st_d.rf_start   = 1'b1;
                    st_d.card_start = 1'b1;
                    st_d.cd         = wut_pkg::WUT_CD_RF;
                end
            end
            wut_pkg::WUT_CD_RF: begin
                if (rf_window_done_i) begin
                    st_d.cd = wut_pkg::WUT_CD_MEAS;
                end
            end
            wut_pkg::WUT_CD_MEAS: begin
                if (card_detect_done_i) begin
                    st_d.cd = wut_pkg::WUT_CD_IDLE;
                    if (card_found_i) begin
                        st_d.card_irq = 1'b1;
                        st_d.stay     = st_q.stay_en;
                    end else begin
                        st_d.pd_req = st_q.pd_en;
                    end
                end
            end
            default: st_d.cd = wut_pkg::WUT_CD_IDLE;
        endcase

        // Register writes
        if (ctrl_wr) begin
            st_d.auto_trim   = wb_dat_i[wut_pkg::CTRL_TRIM_BIT];
            st_d.auto_card   = wb_dat_i[wut_pkg::CTRL_CARD_BIT];
            st_d.auto_reload = wb_dat_i[wut_pkg::CTRL_RELOAD_BIT];
            st_d.auto_wake   = wb_dat_i[wut_pkg::CTRL_WAKE_BIT];
            st_d.clksel      = wb_dat_i[wut_pkg::CTRL_CLKSEL_LSB+:2];
            if (start_wr) begin
                st_d.running = wb_dat_i[wut_pkg::CTRL_RUNNING_BIT];
                st_d.pre     = 5'h00;
                if (wb_dat_i[wut_pkg::CTRL_RUNNING_BIT]) begin
                    st_d.cnt = st_q.reload;
                end
            end
        end
        if (bus_wr & (idx == wut_pkg::IDX_RELOAD_HIGH)) begin
            st_d.reload[15:8] = wb_dat_i[7:0];
        end
        if (bus_wr & (idx == wut_pkg::IDX_RELOAD_LOW)) begin
            st_d.reload[7:0] = wb_dat_i[7:0];
        end
        if (bus_wr & (idx == wut_pkg::IDX_AUX_CONTROL)) begin
            st_d.pd_en   = wb_dat_i[wut_pkg::AUX_PD_EN_BIT];
            st_d.stay_en = wb_dat_i[wut_pkg::AUX_STAY_EN_BIT];
        end
        // Write one clears the flag; a new underflow in the same cycle wins
        if (bus_wr & (idx == wut_pkg::IDX_STATUS) & wb_dat_i[wut_pkg::STATUS_FLAG_BIT] & ~underflow) begin
            st_d.flag = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q             <= '0;
            st_q.cnt         <= wut_pkg::COUNT_RESET;
            st_q.reload      <= wut_pkg::RELOAD_RESET;
            st_q.auto_trim   <= wut_pkg::CONTROL_RESET[wut_pkg::CTRL_TRIM_BIT];
            st_q.auto_card   <= wut_pkg::CONTROL_RESET[wut_pkg::CTRL_CARD_BIT];
            st_q.auto_reload <= wut_pkg::CONTROL_RESET[wut_pkg::CTRL_RELOAD_BIT];
            st_q.auto_wake   <= wut_pkg::CONTROL_RESET[wut_pkg::CTRL_WAKE_BIT];
            st_q.clksel      <= wut_pkg::CONTROL_RESET[wut_pkg::CTRL_CLKSEL_LSB+:2];
            st_q.running     <= wut_pkg::CONTROL_RESET[wut_pkg::CTRL_RUNNING_BIT];
            st_q.pd_en       <= wut_pkg::AUX_RESET[wut_pkg::AUX_PD_EN_BIT];
            st_q.stay_en     <= wut_pkg::AUX_RESET[wut_pkg::AUX_STAY_EN_BIT];
            st_q.cd          <= wut_pkg::WUT_CD_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign wb_dat_o                = {24'h000000, st_q.rdata};
    assign wb_ack_o                = st_q.ack;
    assign wakeup_running_o        = st_q.running;
    assign wakeup_underflow_flag_o = st_q.flag;
    assign wake_req_o              = st_q.wake;
    assign osc_trim_start_o        = st_q.trim_start;
    assign rf_window_start_o       = st_q.rf_start;
    assign rf_field_en_o           = (st_q.cd == wut_pkg::WUT_CD_RF);
    assign card_detect_start_o     = st_q.card_start;
    assign card_irq_o              = st_q.card_irq;
    assign stay_active_o           = st_q.stay;
    assign power_down_req_o        = st_q.pd_req;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_underflow_sets_flag: assert property (underflow |=> wakeup_underflow_flag_o)
        else $error("underflow did not set the flag");

    a_stop_without_reload: assert property (
        underflow && !st_q.auto_reload && !st_q.auto_card |=> !wakeup_running_o && st_q.cnt == 16'h0000)
        else $error("counter did not stop at underflow");

    a_reload_at_zero: assert property (
        underflow && st_q.auto_reload |=> wakeup_running_o && st_q.cnt == $past(st_q.reload))
        else $error("counter did not reload at underflow");

    a_card_restart_nogap: assert property (
        underflow && st_q.auto_card |=> wakeup_running_o && st_q.cnt == $past(st_q.reload))
        else $error("counter did not restart after card detect underflow");

    a_strobe_gates_run: assert property (
        ctrl_wr && !wb_dat_i[6] |=> wakeup_running_o == $past(wakeup_running_o))
        else $error("running changed without the strobe bit");

    a_start_loads_reload: assert property (
        ctrl_wr && wb_dat_i[6] && wb_dat_i[7] |=> wakeup_running_o && st_q.cnt == $past(st_q.reload))
        else $error("start did not load the reload value");

    a_tick_decrements: assert property (
        tick && wakeup_running_o && st_q.cnt != 16'h0000 && !ctrl_wr |=> st_q.cnt == $past(st_q.cnt) - 16'h0001)
        else $error("counter did not decrement on tick");

    a_wake_on_underflow: assert property (
        underflow && st_q.auto_wake |=> wake_req_o ##1 !wake_req_o)
        else $error("wake request missing or longer than one cycle");

    a_trim_on_underflow: assert property (underflow |=> osc_trim_start_o == $past(st_q.auto_trim))
        else $error("trim start does not follow auto trim");

    a_card_seq_start: assert property (
        underflow && st_q.auto_card && st_q.cd == wut_pkg::WUT_CD_IDLE
        |=> card_detect_start_o && rf_window_start_o && rf_field_en_o)
        else $error("card detection did not start");

    a_no_card_powerdown: assert property (
        st_q.cd == wut_pkg::WUT_CD_MEAS && card_detect_done_i && !card_found_i && st_q.pd_en
        |=> power_down_req_o && !card_irq_o)
        else $error("no card but no power-down request");

    a_ctrl_readback: assert property (
        bus_req && !wb_ack_o && idx == wut_pkg::IDX_CONTROL
        |=> wb_ack_o && !wb_dat_o[6] && wb_dat_o[7] == $past(wakeup_running_o))
        else $error("control read back wrong");

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

// File: test_wakeup_timer.sv
`timescale 1ns/1ns
module test_wakeup_timer;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, low_freq_osc_clock, rf_done, cd_done, found;
    logic        running, flag, wake, trim, rfs, field, cds, irq, stay, pdr;
    int          error_cnt, checked;
    int          wake_n, trim_n, rfs_n, cds_n, irq_n, stay_n, pd_n;
    logic [15:0] v;
    // ---------------------------------------------------------------
    // Clock, pulse counters and device
    // ---------------------------------------------------------------
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        wake_n <= wake_n + int'(wake === 1'b1);
        trim_n <= trim_n + int'(trim === 1'b1);
        rfs_n  <= rfs_n + int'(rfs === 1'b1);
        cds_n  <= cds_n + int'(cds === 1'b1);
        irq_n  <= irq_n + int'(irq === 1'b1);
        stay_n <= stay_n + int'(stay === 1'b1);
        pd_n   <= pd_n + int'(pdr === 1'b1);
    end
    wut_wakeup_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_freq_osc_clock_i(low_freq_osc_clock),
        .rf_window_done_i(rf_done), .card_detect_done_i(cd_done), .card_found_i(found),
        .wakeup_running_o(running), .wakeup_underflow_flag_o(flag), .wake_req_o(wake),
        .osc_trim_start_o(trim), .rf_window_start_o(rfs), .rf_field_en_o(field),
        .card_detect_start_o(cds), .card_irq_o(irq), .stay_active_o(stay), .power_down_req_o(pdr));
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic end_sim;
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] q);
        int   n;
        logic ok;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        ok = (wb_ack_o === 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        // Let the write taken at the ack edge settle before outputs are compared
        @(negedge clk_i);
        if (!ok) begin
            error_cnt++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb_xfer(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [5:0] idx, output logic [7:0] q);
        wb_xfer(1'b0, idx, 8'h00, q);
    endtask
    task automatic rd16(input logic [5:0] idx, output logic [15:0] q);
        rd(idx, q[15:8]);
        rd(idx + 6'h01, q[7:0]);
    endtask
    task automatic wr_reload(input logic [15:0] d);
        wr(wut_pkg::IDX_RELOAD_HIGH, d[15:8]);
        wr(wut_pkg::IDX_RELOAD_LOW, d[7:0]);
    endtask
    // One LOW_FREQ_OSC_CLOCK period of nine system clocks, long enough for the count to settle
    task automatic lfo_tick(input int k);
        repeat (k) begin
            @(posedge clk_i);
            low_freq_osc_clock <= 1'b1;
            repeat (4) @(posedge clk_i);
            low_freq_osc_clock <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    task automatic pulse_in(input logic which, input logic f);
        @(posedge clk_i);
        if (which) begin
            cd_done <= 1'b1;
        end else begin
            rf_done <= 1'b1;
        end
        found <= f;
        @(posedge clk_i);
        cd_done <= 1'b0;
        rf_done <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, low_freq_osc_clock, rf_done, cd_done, found} = 8'h00;
        {wake_n, trim_n, rfs_n, cds_n, irq_n, stay_n, pd_n, error_cnt, checked} = '0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(wut_pkg::IDX_CONTROL, v[7:0]);
        check(v[7:0], 8'h00);
        rd(6'h3F, v[7:0]);
        check(v[7:0], 8'h00);
        wr_reload(16'h1234);
        rd16(wut_pkg::IDX_RELOAD_HIGH, v);
        check(v, 16'h1234);
        wr(wut_pkg::IDX_COUNT_LOW, 8'hFF);
        rd16(wut_pkg::IDX_COUNT_HIGH, v);
        check(v, 16'h0000);
        wr(wut_pkg::IDX_CONTROL, 8'h80);
        check(running, 1'b0);
        // One-shot countdown, undivided clock
        wr_reload(16'h0003);
        wr(wut_pkg::IDX_CONTROL, 8'hC0);
        rd16(wut_pkg::IDX_COUNT_HIGH, v);
        check(v, 16'h0003);
        rd(wut_pkg::IDX_CONTROL, v[7:0]);
        check(v[7:0], 8'h80);
        lfo_tick(1);
        rd16(wut_pkg::IDX_COUNT_HIGH, v);
        check(v, 16'h0002);
        wr(wut_pkg::IDX_RELOAD_LOW, 8'h05);
        lfo_tick(2);
        rd16(wut_pkg::IDX_COUNT_HIGH, v);
        check(v, 16'h0000);
        check({flag, running}, 2'h1);
        lfo_tick(1);
        check({flag, running}, 2'h2);
        rd16(wut_pkg::IDX_COUNT_HIGH, v);
        check(v, 16'h0000);
        rd(wut_pkg::IDX_STATUS, v[7:0]);
        check(v[7:0], 8'h01);
        wr(wut_pkg::IDX_STATUS, 8'h01);
        check(flag, 1'b0);
        // Auto reload with wake and trim
        wr_reload(16'h0001);
        wr(wut_pkg::IDX_CONTROL, 8'hEC);
        rd(wut_pkg::IDX_CONTROL, v[7:0]);
        check(v[7:0], 8'hAC);
        lfo_tick(2);
        rd16(wut_pkg::IDX_COUNT_HIGH, v);
        check(v, 16'h0001);
        check({running, flag}, 2'h3);
        check(16'(wake_n), 16'h0001);
        check(16'(trim_n), 16'h0001);
        wr(wut_pkg::IDX_CONTROL, 8'h40);
        check(running, 1'b0);
        // Divided clocks, each code
        wr_reload(16'h0005);
        for (int s = 1; s < 4; s++) begin
            wr(wut_pkg::IDX_CONTROL, 8'hC0 | 8'(s));
            lfo_tick((4 << s) - 1);
            rd16(wut_pkg::IDX_COUNT_HIGH, v);
            check(v, 16'h0005);
            lfo_tick(1);
            rd16(wut_pkg::IDX_COUNT_HIGH, v);
            check(v, 16'h0004);
        end
        // Card detection: found, then not found
        wr(wut_pkg::IDX_AUX_CONTROL, 8'h03);
        wr_reload(16'h0000);
        wr(wut_pkg::IDX_CONTROL, 8'hD4);
        lfo_tick(1);
        check({running, field}, 2'h3);
        check(16'(rfs_n + cds_n), 16'h0002);
        pulse_in(1'b0, 1'b0);
        check(field, 1'b0);
        pulse_in(1'b1, 1'b1);
        check(16'({irq_n[3:0], stay_n[3:0], pd_n[3:0]}), 16'h0110);
        check(running, 1'b1);
        lfo_tick(1);
        check(16'(cds_n), 16'h0002);
        pulse_in(1'b0, 1'b0);
        pulse_in(1'b1, 1'b0);
        check(16'({irq_n[3:0], pd_n[3:0]}), 16'h0011);
        wr(wut_pkg::IDX_CONTROL, 8'h40);
        check(running, 1'b0);
        end_sim();
    end
endmodule
